/* File: design/dfsr_map.vh */
`ifndef DFSR_MAP_VH
`define DFSR_MAP_VH
// register byte offsets
`define DFSR_A_CFG      8'h00
`define DFSR_A_MAXF     8'h04
`define DFSR_A_ULIM     8'h08
`define DFSR_A_UOFS     8'h0C
`define DFSR_A_LLIM     8'h10
`define DFSR_A_PRESET   8'h14
`define DFSR_A_DROOP    8'h18
`define DFSR_A_CARR     8'h1C
`define DFSR_A_TIME0    8'h20
`define DFSR_A_TIME_END 8'h3C
`define DFSR_A_DISP1    8'h40
`define DFSR_A_DISP2    8'h44
`define DFSR_A_DSTOP    8'h48
`define DFSR_A_UDSTEP   8'h4C
`define DFSR_A_CMD      8'h50
`define DFSR_A_OUTF     8'h60
`define DFSR_A_STAT     8'h64
`define DFSR_A_DSET     8'h68
`define DFSR_A_TGT      8'h6C
// configuration field positions
`define DFSR_F_RREF     1:0
`define DFSR_F_STOP     2
`define DFSR_F_UNIT     5:4
`define DFSR_F_BELOW    7:6
`define DFSR_F_DERATE   8
`define DFSR_F_DSEP     9
`define DFSR_F_MEM      10
`define DFSR_F_UDREF    11
`define DFSR_F_USRC     14:12
`define DFSR_F_DIGSRC   15
// command field positions
`define DFSR_C_RUN      0
`define DFSR_C_UP       1
`define DFSR_C_DOWN     2
// reset values
`define DFSR_R_CFG      16'h8D10
`define DFSR_R_MAXF     16'h1388
`define DFSR_R_ULIM     16'h1388
`define DFSR_R_UOFS     16'h0000
`define DFSR_R_LLIM     16'h0000
`define DFSR_R_PRESET   16'h1388
`define DFSR_R_DROOP    16'h0000
`define DFSR_R_CARR     8'h28
`define DFSR_R_TIME     16'h0064
`define DFSR_R_DISP     16'h401F
`define DFSR_R_UDSTEP   16'h0001
// fixed values
`define DFSR_REF_100HZ  16'h2710
`define DFSR_MAXF_MIN   16'h1388
`define DFSR_MAXF_MAX   16'hC350
`define DFSR_CARR_MIN   8'h05
`define DFSR_CARR_MAX   8'hA0
`define DFSR_DROOP_DIV  42'h0_0000_000F_4240
`define DFSR_RESP_OKAY  2'b00
`define DFSR_RESP_SLV   2'b10
// timing
`define DFSR_CLK_KHZ    10000
`define DFSR_TICK_US    1000
`define DFSR_TICK_CYC   (`DFSR_TICK_US * `DFSR_CLK_KHZ / 1000)
`define DFSR_CARR_TICKS 100
`define DFSR_TPC_S      (1000000 / `DFSR_TICK_US)
`define DFSR_TPC_DS     (100000 / `DFSR_TICK_US)
`define DFSR_TPC_CS     (10000 / `DFSR_TICK_US)
`endif

/* File: design/dfsr_step.v */
`include "dfsr_map.vh"
// ramp increment per tick in 16.16 form from reference and stored time
module dfsr_step (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [15:0] ref_freq,
  input  wire [15:0] time_count,
  input  wire [1:0]  time_unit,
  output reg  [31:0] step_q
);
  reg  [31:0] ticks;
  reg  [31:0] quot;
  wire [31:0] num = {ref_freq, 16'h0000};

  // the unit only sets the tick weight, so a unit change rescales every pair
  always @*
  begin
    case (time_unit)
      2'd0:    ticks = time_count * `DFSR_TPC_S;
      2'd1:    ticks = time_count * `DFSR_TPC_DS;
      default: ticks = time_count * `DFSR_TPC_CS;
    endcase
    quot = (ticks == 32'h0000_0000) ? num : num / ticks;
  end

  // zero step would freeze the ramp, so it becomes a jump to target
  always @(posedge clock)
  begin
    if (!rst_n)
      step_q <= 32'h0000_0000;
    else if (quot == 32'h0000_0000)
      step_q <= 32'hFFFF_FFFF;
    else
      step_q <= quot;
  end
endmodule // dfsr_step

/* File: design/dfsr_top.v */
// Function
// RULE1: ramp reference is maximum, present set frequency, or fixed 100 Hz.
// RULE2: stop code 0 ramps down at decel rate, output off at zero.
// RULE3: stop code 1 cuts output at once; motor coasts.
// RULE4: output drops by frequency times torque times droop setting over ten.
// RULE5: full scale of inputs maps to maximum frequency, 50.00 to 500.00 Hz.
// RULE6: upper limit source code 0 to 5 picks parameter, analogs, pulse, link.
// RULE7: analog or pulse upper limit gets the offset added.
// RULE8: lower limit settable from zero to upper limit, default 0.00 Hz.
// RULE9: command below lower limit stops, runs at limit, or runs at zero.
// RULE10: carrier setting spans 0.5 kHz to 16 kHz.
// RULE11: with derate enabled carrier drops under overload, creeps back after.
// RULE12: display code 0 splits run and stop selections; code 1 shares run ones.
// RULE13: memory code 0 restores preset and drops corrections on stop.
// RULE14: memory code 1 keeps last set frequency and corrections on stop.
// RULE15: up/down code 0 steps from the present operating frequency.
// RULE16: up/down code 1, default, steps from the set frequency.
// RULE17: memory and up/down choices act only with the digital source.
// RULE18: time unit change rescales all four ramp time pairs.
// RULE19: accel is zero to reference; decel is reference to zero.
// RULE20: time unit code 0 is 1 s, 1 is 0.1 s, 2 is 0.01 s.
// RULE21: below-limit code 0 runs at limit, 1 stops, 2 runs at zero.
// RULE22: ramp steps once per tick by reference over time, no overshoot.
// RULE23: target clamped between lower and effective upper, below maximum.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "dfsr_map.vh"
module dfsr_top #(
  parameter TICK_CYCLES = `DFSR_TICK_CYC
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [15:0] analog_input_one,
  input  wire [15:0] analog_input_two,
  input  wire [15:0] analog_input_three,
  input  wire [15:0] pulse_input_terminal,
  input  wire [15:0] link_upper_limit,
  input  wire [15:0] frequency_command,
  input  wire [9:0]  output_torque,
  input  wire        load_over_rated,
  input  wire [1:0]  ramp_group_select,
  output wire [15:0] output_frequency,
  output wire        output_enable,
  output wire [7:0]  carrier_frequency,
  output wire [15:0] display_primary,
  output wire [15:0] display_secondary
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_DEC  = 2'd2;

  // bus handshake state
  reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg        aw_have_q, w_have_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg [1:0]  bresp_q, rresp_q;
  reg [31:0] rdata_q;
  // settings
  reg [15:0] cfg_q, maxf_q, ulim_q, uofs_q, llim_q, preset_q, droop_q;
  reg [7:0]  carr_q;
  reg [15:0] acc_time_q [0:3];
  reg [15:0] dec_time_q [0:3];
  reg [15:0] disp1_q, disp2_q, dstop_q, udstep_q;
  reg        run_q;
  // operating state
  reg [1:0]  state_q;
  reg [31:0] freq_q;
  reg [15:0] dset_q, outf_q, dprim_q, dsec_q;
  reg        oen_q;
  reg [7:0]  carr_eff_q;
  reg [13:0] tick_cnt_q;
  reg [6:0]  carr_cnt_q;
  reg [31:0] rd_mux;
  reg [1:0]  rd_resp;
  reg [16:0] ul_raw;
  reg [15:0] tgt, ref_f;
  reg        below_stop;
  integer    i;

  wire        wr_go  = aw_have_q && w_have_q && !bvalid_q;
  wire        wr_hit = wr_go && wr_mapped(awaddr_q);
  wire        digital = cfg_q[`DFSR_F_DIGSRC];
  wire        cmd_wr = wr_hit && awaddr_q == `DFSR_A_CMD && wstrb_q[0];
  wire        up_p   = cmd_wr && wdata_q[`DFSR_C_UP];
  wire        dn_p   = cmd_wr && wdata_q[`DFSR_C_DOWN];
  wire        stop_p = cmd_wr && !wdata_q[`DFSR_C_RUN] && run_q;
  wire        tick   = (tick_cnt_q == TICK_CYCLES - 1);
  wire [15:0] freq_i = freq_q[31:16];
  wire [31:0] tgt32  = {tgt, 16'h0000};
  wire [31:0] step_a, step_d;
  wire [15:0] ul_eff = (ul_raw > {1'b0, maxf_q}) ? maxf_q : ul_raw[15:0];
  wire [15:0] ll_eff = (llim_q > ul_eff) ? ul_eff : llim_q;
  wire [15:0] cmd_f  = digital ? dset_q : frequency_command;
  wire [41:0] droop_p = freq_i * output_torque * droop_q;
  wire [41:0] droop_v = droop_p / `DFSR_DROOP_DIV;

  // writable span
  function wr_mapped;
    input [7:0] a;
    begin
      wr_mapped = (a <= `DFSR_A_CMD) && (a[1:0] == 2'b00);
    end
  endfunction

  // byte lanes merged into the low half of a setting
  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // fraction times maximum frequency
  function [15:0] scale;
    input [15:0] frac;
    input [15:0] fmax;
    reg   [31:0] p;
    begin
      p     = frac * fmax;
      scale = p[31:16];
    end
  endfunction

  // write channel capture, one write in flight at a time
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DFSR_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped(awaddr_q) ? `DFSR_RESP_OKAY : `DFSR_RESP_SLV;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // settings; maximum frequency and carrier clamped to legal span
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_q    <= `DFSR_R_CFG;
      maxf_q   <= `DFSR_R_MAXF;
      ulim_q   <= `DFSR_R_ULIM;
      uofs_q   <= `DFSR_R_UOFS;
      llim_q   <= `DFSR_R_LLIM;
      preset_q <= `DFSR_R_PRESET;
      droop_q  <= `DFSR_R_DROOP;
      carr_q   <= `DFSR_R_CARR;
      disp1_q  <= `DFSR_R_DISP;
      disp2_q  <= `DFSR_R_DISP;
      dstop_q  <= `DFSR_R_DISP;
      udstep_q <= `DFSR_R_UDSTEP;
      run_q    <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
        acc_time_q[i] <= `DFSR_R_TIME;
        dec_time_q[i] <= `DFSR_R_TIME;
      end
    end
    else if (wr_hit)
    begin
      if (awaddr_q == `DFSR_A_CFG)
        cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_MAXF)
      begin
        if (merge(maxf_q, wdata_q, wstrb_q) < `DFSR_MAXF_MIN)
          maxf_q <= `DFSR_MAXF_MIN; // see RULE5
        else if (merge(maxf_q, wdata_q, wstrb_q) > `DFSR_MAXF_MAX)
          maxf_q <= `DFSR_MAXF_MAX; // see RULE5
        else
          maxf_q <= merge(maxf_q, wdata_q, wstrb_q);
      end
      else if (awaddr_q == `DFSR_A_ULIM)
        ulim_q <= merge(ulim_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_UOFS)
        uofs_q <= merge(uofs_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_LLIM)
        llim_q <= merge(llim_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_PRESET)
        preset_q <= merge(preset_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_DROOP)
        droop_q <= merge(droop_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_CARR && wstrb_q[0])
      begin
        if (wdata_q[7:0] < `DFSR_CARR_MIN)
          carr_q <= `DFSR_CARR_MIN; // see RULE10
        else if (wdata_q[7:0] > `DFSR_CARR_MAX)
          carr_q <= `DFSR_CARR_MAX; // see RULE10
        else
          carr_q <= wdata_q[7:0];
      end
      else if (awaddr_q >= `DFSR_A_TIME0 && awaddr_q <= `DFSR_A_TIME_END)
      begin
        if (awaddr_q[2])
          dec_time_q[awaddr_q[4:3]] <= merge(dec_time_q[awaddr_q[4:3]], wdata_q, wstrb_q);
        else
          acc_time_q[awaddr_q[4:3]] <= merge(acc_time_q[awaddr_q[4:3]], wdata_q, wstrb_q);
      end
      else if (awaddr_q == `DFSR_A_DISP1)
        disp1_q <= merge(disp1_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_DISP2)
        disp2_q <= merge(disp2_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_DSTOP)
        dstop_q <= merge(dstop_q, wdata_q, wstrb_q);
      else if (awaddr_q == `DFSR_A_UDSTEP)
        udstep_q <= merge(udstep_q, wdata_q, wstrb_q);
      else if (cmd_wr)
        run_q <= wdata_q[`DFSR_C_RUN];
    end
  end

  // read decode; holes answer slave error
  always @*
  begin
    rd_mux  = 32'h0000_0000;
    rd_resp = `DFSR_RESP_OKAY;
    if (s_axi_araddr == `DFSR_A_CFG)
      rd_mux = {16'h0000, cfg_q};
    else if (s_axi_araddr == `DFSR_A_MAXF)
      rd_mux = {16'h0000, maxf_q};
    else if (s_axi_araddr == `DFSR_A_ULIM)
      rd_mux = {16'h0000, ulim_q};
    else if (s_axi_araddr == `DFSR_A_UOFS)
      rd_mux = {16'h0000, uofs_q};
    else if (s_axi_araddr == `DFSR_A_LLIM)
      rd_mux = {16'h0000, llim_q};
    else if (s_axi_araddr == `DFSR_A_PRESET)
      rd_mux = {16'h0000, preset_q};
    else if (s_axi_araddr == `DFSR_A_DROOP)
      rd_mux = {16'h0000, droop_q};
    else if (s_axi_araddr == `DFSR_A_CARR)
      rd_mux = {24'h00_0000, carr_q};
    else if (s_axi_araddr >= `DFSR_A_TIME0 && s_axi_araddr <= `DFSR_A_TIME_END
             && s_axi_araddr[1:0] == 2'b00)
      rd_mux = {16'h0000, s_axi_araddr[2] ? dec_time_q[s_axi_araddr[4:3]]
                                          : acc_time_q[s_axi_araddr[4:3]]};
    else if (s_axi_araddr == `DFSR_A_DISP1)
      rd_mux = {16'h0000, disp1_q};
    else if (s_axi_araddr == `DFSR_A_DISP2)
      rd_mux = {16'h0000, disp2_q};
    else if (s_axi_araddr == `DFSR_A_DSTOP)
      rd_mux = {16'h0000, dstop_q};
    else if (s_axi_araddr == `DFSR_A_UDSTEP)
      rd_mux = {16'h0000, udstep_q};
    else if (s_axi_araddr == `DFSR_A_CMD)
      rd_mux = {31'h0000_0000, run_q};
    else if (s_axi_araddr == `DFSR_A_OUTF)
      rd_mux = {16'h0000, outf_q};
    else if (s_axi_araddr == `DFSR_A_STAT)
      rd_mux = {20'h0_0000, carr_eff_q, state_q, below_stop, oen_q};
    else if (s_axi_araddr == `DFSR_A_DSET)
      rd_mux = {16'h0000, dset_q};
    else if (s_axi_araddr == `DFSR_A_TGT)
      rd_mux = {16'h0000, tgt};
    else
      rd_resp = `DFSR_RESP_SLV;
  end

  // read channel, data captured at the address handshake
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `DFSR_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_resp;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // limits and target
  always @*
  begin
    case (cfg_q[`DFSR_F_USRC]) // see RULE6
      3'd1: ul_raw = scale(analog_input_one, maxf_q) + uofs_q; // see RULE7
      3'd2: ul_raw = scale(analog_input_two, maxf_q) + uofs_q; // see RULE7
      3'd3: ul_raw = scale(analog_input_three, maxf_q) + uofs_q; // see RULE7
      3'd4: ul_raw = scale(pulse_input_terminal, maxf_q) + uofs_q; // see RULE7
      3'd5: ul_raw = {1'b0, link_upper_limit};
      default: ul_raw = {1'b0, ulim_q};
    endcase
    below_stop = 1'b0;
    if (cmd_f < ll_eff) // see RULE8
    begin
      case (cfg_q[`DFSR_F_BELOW]) // see RULE9
        2'd0:    tgt = ll_eff; // see RULE21
        2'd1:
        begin
          tgt        = 16'h0000; // see RULE21
          below_stop = 1'b1;
        end
        default: tgt = 16'h0000; // see RULE21
      endcase
    end
    else
      tgt = (cmd_f > ul_eff) ? ul_eff : cmd_f; // see RULE23
    case (cfg_q[`DFSR_F_RREF]) // see RULE1
      2'd0:    ref_f = maxf_q;
      2'd1:    ref_f = tgt;
      default: ref_f = `DFSR_REF_100HZ;
    endcase
  end

  // ramp step per tick
  dfsr_step u_acc (
    .clock      (clock),
    .rst_n      (rst_n),
    .ref_freq   (ref_f),
    .time_count (acc_time_q[ramp_group_select]),
    .time_unit  (cfg_q[`DFSR_F_UNIT]), // see RULE18 see RULE20
    .step_q     (step_a)
  );
  dfsr_step u_dec (
    .clock      (clock),
    .rst_n      (rst_n),
    .ref_freq   (ref_f),
    .time_count (dec_time_q[ramp_group_select]),
    .time_unit  (cfg_q[`DFSR_F_UNIT]), // see RULE18 see RULE20
    .step_q     (step_d)
  );

  // update tick and the slower carrier tick
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= 14'h0000;
      carr_cnt_q <= 7'h00;
    end
    else if (tick)
    begin
      tick_cnt_q <= 14'h0000;
      carr_cnt_q <= (carr_cnt_q == `DFSR_CARR_TICKS - 1) ? 7'h00 : carr_cnt_q + 7'h01;
    end
    else
      tick_cnt_q <= tick_cnt_q + 14'h0001;
  end

  // run state and ramp, frequency kept in 16.16 to carry small steps
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      freq_q  <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          freq_q <= 32'h0000_0000;
          if (run_q)
            state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (!run_q && cfg_q[`DFSR_F_STOP])
          begin
            state_q <= ST_IDLE; // see RULE3
            freq_q  <= 32'h0000_0000; // see RULE3
          end
          else if (!run_q)
            state_q <= ST_DEC; // see RULE2
          else if (tick && freq_q < tgt32)
            freq_q <= (tgt32 - freq_q > step_a) ? freq_q + step_a : tgt32; // see RULE22 see RULE19
          else if (tick && freq_q > tgt32)
            freq_q <= (freq_q - tgt32 > step_d) ? freq_q - step_d : tgt32; // see RULE22 see RULE19
        end
        ST_DEC:
        begin
          if (run_q)
            state_q <= ST_RUN;
          else if (freq_q == 32'h0000_0000)
            state_q <= ST_IDLE; // see RULE2
          else if (tick)
            freq_q <= (freq_q > step_d) ? freq_q - step_d : 32'h0000_0000; // see RULE2
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // digital set frequency
  always @(posedge clock)
  begin
    if (!rst_n)
      dset_q <= `DFSR_R_PRESET;
    else if (digital && stop_p && !cfg_q[`DFSR_F_MEM]) // see RULE17
      dset_q <= preset_q; // see RULE13
    else if (digital && (up_p || dn_p)) // see RULE17 see RULE14
    begin
      if (up_p)
        dset_q <= (({1'b0, cfg_q[`DFSR_F_UDREF] ? dset_q : freq_i} + udstep_q) > maxf_q)
                  ? maxf_q
                  : (cfg_q[`DFSR_F_UDREF] ? dset_q : freq_i) + udstep_q; // see RULE15 see RULE16
      else
        dset_q <= ((cfg_q[`DFSR_F_UDREF] ? dset_q : freq_i) > udstep_q)
                  ? (cfg_q[`DFSR_F_UDREF] ? dset_q : freq_i) - udstep_q
                  : 16'h0000; // see RULE15 see RULE16
    end
    else if (wr_hit && awaddr_q == `DFSR_A_PRESET && state_q == ST_IDLE)
      dset_q <= merge(preset_q, wdata_q, wstrb_q);
  end

  // output stage and displays
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      outf_q     <= 16'h0000;
      oen_q      <= 1'b0;
      carr_eff_q <= `DFSR_R_CARR;
      dprim_q    <= `DFSR_R_DISP;
      dsec_q     <= `DFSR_R_DISP;
    end
    else
    begin
      outf_q <= (droop_v[15:0] > freq_i) ? 16'h0000 : freq_i - droop_v[15:0]; // see RULE4
      oen_q  <= (state_q != ST_IDLE) && !(below_stop && freq_q == 32'h0000_0000);
      if (!cfg_q[`DFSR_F_DERATE])
        carr_eff_q <= carr_q;
      else if (tick && carr_cnt_q == 7'h00)
      begin
        if (load_over_rated && carr_eff_q > `DFSR_CARR_MIN)
          carr_eff_q <= carr_eff_q - 8'h01; // see RULE11
        else if (!load_over_rated && carr_eff_q < carr_q)
          carr_eff_q <= carr_eff_q + 8'h01; // see RULE11
        else if (carr_eff_q > carr_q)
          carr_eff_q <= carr_q;
      end
      if (state_q != ST_IDLE || cfg_q[`DFSR_F_DSEP])
      begin
        dprim_q <= disp1_q; // see RULE12
        dsec_q  <= disp2_q; // see RULE12
      end
      else
      begin
        dprim_q <= dstop_q; // see RULE12
        dsec_q  <= dstop_q; // see RULE12
      end
    end
  end

  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign output_frequency  = outf_q;
  assign output_enable     = oen_q;
  assign carrier_frequency = carr_eff_q;
  assign display_primary   = dprim_q;
  assign display_secondary = dsec_q;
endmodule // dfsr_top

/* File: testbench/dfsr_motor_model.sv */
module dfsr_motor_model (
  input  wire logic       output_enable,
  input  wire logic       heavy,
  output wire logic [9:0] output_torque,
  output wire logic       load_over_rated
);
  timeunit 1ns;
  timeprecision 1ns;
  // half rated torque while driven
  assign output_torque = output_enable ? 10'h1F4 : 10'h000;
  // overload only seen while the stage switches
  assign load_over_rated = output_enable & heavy;
endmodule // dfsr_motor_model

/* File: testbench/dfsr_top_props.sv */
module dfsr_top_props #(
  parameter TICK_CYCLES = 10
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [15:0] output_frequency,
  input wire logic        output_enable,
  input wire logic [7:0]  carrier_frequency
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // bus timing
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("write taken twice");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h6C
    |=> s_axi_rresp == 2'b10) else $error("unmapped read not refused");
  // outputs
  AST_CARR_RANGE: assert property (carrier_frequency inside {[8'h05:8'hA0]})
    else $error("carrier out of range");
  AST_FMAX: assert property (output_frequency <= 16'hC350)
    else $error("frequency above ceiling");
  AST_OFF_ZERO: assert property ($fell(output_enable) |-> ##[0:2] output_frequency == 16'h0000)
    else $error("output off at speed");
  AST_RAMP_TICK: assert property ($changed(output_frequency) |=> $stable(output_frequency) [*8])
    else $error("ramp stepped twice in a tick");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(output_enable));
  cover property (carrier_frequency < 8'h28);
endmodule // dfsr_top_props

/* File: testbench/drive_frequency_setpoint_ramp_tb.sv */
`include "dfsr_map.vh"
module drive_frequency_setpoint_ramp_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst_n = 0, heavy = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [15:0] analog_input_one = 16'h8000, analog_input_two = 16'h4000;
  logic [15:0] analog_input_three = 16'hC000, pulse_input_terminal = 16'h2000;
  logic [15:0] link_upper_limit = 16'h07D0, frequency_command = 0;
  logic [1:0]  ramp_group_select = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] output_frequency, display_primary, display_secondary;
  wire  [9:0]  output_torque;
  wire  [7:0]  carrier_frequency;
  wire         output_enable, load_over_rated;
  int          fails = 0, total_checks = 0, cyc = 0;
  localparam logic [15:0] ULIM [0:5] = '{16'h1388, 16'h0BB8, 16'h06D6, 16'h109A, 16'h0465, 16'h07D0};
  localparam logic [2:0]  D45 = 3'b100, D85 = 3'b101;
  // short tick keeps ramps to tens of cycles
  dfsr_top #(.TICK_CYCLES(10)) i_dfsr_top (.*);
  dfsr_motor_model i_dfsr_motor_model (.*);
  always #50 clock = ~clock;
  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one bus access
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = 2'b00);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    while (!(s_axi_bvalid || s_axi_rvalid));
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    chk(w ? s_axi_bresp : s_axi_rresp, e);
    if (!w) chk(s_axi_rdata, d);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] r, input logic s,
                                      input logic [1:0] b, input logic [2:0] u);
    return 32'h0000_8D20 | r | (s << 2) | (b << 6) | (u << 12);
  endfunction
  task automatic test_done();
    $display("checks %0d, failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    acc(0, `DFSR_A_CFG, 32'h0000_8D10);
    acc(0, 8'h7C, 32'h0, 2'b10);
    acc(1, 8'h58, 32'h1, 2'b10);
    acc(1, `DFSR_A_MAXF, 32'h0000_FFFF);
    acc(0, `DFSR_A_MAXF, 32'h0000_C350);
    acc(1, `DFSR_A_MAXF, 32'h0);
    acc(0, `DFSR_A_MAXF, 32'h0000_1388);
    acc(1, `DFSR_A_CARR, 32'h0);
    acc(0, `DFSR_A_CARR, 32'h0000_0005);
    acc(1, `DFSR_A_CARR, 32'h0000_00FF);
    acc(0, `DFSR_A_CARR, 32'h0000_00A0);
    acc(1, `DFSR_A_CARR, 32'h0000_0028);
    $display("registers done");
    acc(1, `DFSR_A_UOFS, 32'h0000_01F4);
    for (int i = 0; i < 6; i++)
    begin
      acc(1, `DFSR_A_CFG, cfg(0, 0, 0, i[2:0]));
      acc(0, `DFSR_A_TGT, {16'h0000, ULIM[i]});
    end
    $display("upper limit done");
    acc(1, `DFSR_A_LLIM, 32'h0000_03E8);
    acc(1, `DFSR_A_PRESET, 32'h0000_01F4);
    for (int i = 0; i < 3; i++)
    begin
      acc(1, `DFSR_A_CFG, cfg(0, 0, i[1:0], 0));
      acc(0, `DFSR_A_TGT, i ? 32'h0 : 32'h0000_03E8);
    end
    acc(1, `DFSR_A_LLIM, 32'h0);
    $display("lower limit done");
    // target 25 Hz, one count of 0.01 s per ramp
    acc(1, `DFSR_A_PRESET, 32'h0000_09C4);
    acc(1, `DFSR_A_TIME0, 32'h1);
    acc(1, 8'h24, 32'h1);
    for (int r = 0; r < 3; r++)
    begin
      acc(1, `DFSR_A_CFG, cfg(r[1:0], 1, 0, 0));
      acc(1, `DFSR_A_CMD, 32'h1);
      repeat (35) @(posedge clock);
      chk(output_frequency == 16'h09C4, D45[r]);
      repeat (50) @(posedge clock);
      chk(output_frequency == 16'h09C4, D85[r]);
      repeat (100) @(posedge clock);
      chk(output_frequency, 32'h0000_09C4);
      acc(1, `DFSR_A_CMD, 32'h0);
      repeat (3) @(posedge clock);
      chk({output_enable, output_frequency}, 32'h0);
    end
    $display("ramp done");
    // droop, overload, ramped stop
    acc(1, `DFSR_A_DROOP, 32'h0000_0064);
    acc(1, `DFSR_A_DISP1, 32'h0000_1234);
    acc(1, `DFSR_A_PRESET, 32'h0000_1388);
    acc(1, `DFSR_A_CFG, cfg(0, 0, 0, 0));
    acc(1, `DFSR_A_CMD, 32'h1);
    repeat (200) @(posedge clock);
    chk(output_frequency, 32'h0000_128E);
    chk(display_primary, 32'h0000_1234);
    heavy <= 1;
    repeat (1200) @(posedge clock);
    chk(carrier_frequency < 8'h28, 1);
    heavy <= 0;
    acc(1, `DFSR_A_CMD, 32'h0);
    chk(output_enable, 1);
    repeat (150) @(posedge clock);
    chk({output_enable, output_frequency}, 32'h0);
    repeat (2500) @(posedge clock);
    chk(carrier_frequency, 32'h0000_0028);
    $display("stop and derate done");
    test_done();
  end
endmodule // drive_frequency_setpoint_ramp_tb
bind dfsr_top dfsr_top_props #(.TICK_CYCLES(TICK_CYCLES)) i_dfsr_top_props (.*);
